// [core/i2c_flags_pkg.sv]
// Constants, field layout and state codes of the two-wire slave flag block
package i2c_flags_pkg;
    localparam int CLK_NS           = 50;
    localparam int TIMEOUT_NS       = 50000;
    localparam int TIMEOUT_CYCLES   = TIMEOUT_NS / CLK_NS;
    localparam logic [9:0] TIMEOUT_CNT = 10'(TIMEOUT_CYCLES);

    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_MASK   = 8'h08;
    localparam logic [7:0] OFF_CMD    = 8'h0c;
    localparam logic [7:0] OFF_ADDR   = 8'h10;
    localparam logic [7:0] OFF_DATA   = 8'h14;
    localparam logic [7:0] OFF_LINE   = 8'h18;

    localparam int CTRL_EN     = 0;
    localparam int CTRL_STOPIE = 1;
    localparam int CTRL_TOEN   = 2;
    localparam int ST_DATA     = 0;
    localparam int ST_ADDR     = 1;
    localparam int ST_HOLD     = 2;
    localparam int ST_COLL     = 3;
    localparam int ST_DIR      = 4;
    localparam int CMD_ACKACT  = 2;

    localparam logic [1:0] CMD_COMPLETE = 2'h2;
    localparam logic [1:0] CMD_RESPONSE = 2'h3;
    localparam logic [1:0] LINE_UNKNOWN = 2'h0;
    localparam logic [1:0] LINE_IDLE    = 2'h1;
    localparam logic [1:0] LINE_BUSY    = 2'h3;

    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam logic [4:0] MASK_RST = 5'h00;
    localparam logic [6:0] ADDR_RST = 7'h00;
    localparam logic [3:0] NBITS    = 4'h8;
    localparam logic [4:0] FLAG_BITS = 5'h0b;

    typedef enum logic [2:0] {
        S_IDLE      = 3'b000,
        S_ADDR      = 3'b001,
        S_ADDR_ACK  = 3'b010,
        S_HOLD_ADDR = 3'b011,
        S_RX_DATA   = 3'b100,
        S_RX_ACK    = 3'b101,
        S_TX_DATA   = 3'b110,
        S_TX_ACK    = 3'b111
    } state_t;
endpackage

// [core/line_if.sv]
// Synchronised line levels and bus events passed from the watcher to the core
`timescale 1ns/100ps
interface line_if;
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic timeout;
    logic timeout_en;
    logic busy;
    modport watcher (output scl, sda, scl_rise, scl_fall, start, stop, timeout,
                     input timeout_en, busy);
    modport core (input scl, sda, scl_rise, scl_fall, start, stop, timeout,
                  output timeout_en, busy);
endinterface

// [core/line_watch.sv]
// Pin synchronisers, START/STOP detection and bus timeout counter
`timescale 1ns/100ps
module line_watch (
    input  wire logic pclk,    // Peripheral clock
    input  wire logic presetn, // Asynchronous reset, active low
    input  wire logic scl_in,  // Clock line level from pin
    input  wire logic sda_in,  // Data line level from pin
    line_if.watcher   lw       // Events towards the core
);
    localparam logic [9:0] TIMEOUT_LAST = i2c_flags_pkg::TIMEOUT_CNT - 10'h001;

    logic       scl_m, sda_m, scl_d, sda_d;
    logic [9:0] count;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            scl_m <= 1'b1;
            sda_m <= 1'b1;
            lw.scl <= 1'b1;
            lw.sda <= 1'b1;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end
        else
        begin
            scl_m <= scl_in;
            sda_m <= sda_in;
            lw.scl <= scl_m;
            lw.sda <= sda_m;
            scl_d <= lw.scl;
            sda_d <= lw.sda;
        end
    end

    assign lw.scl_rise = lw.scl & ~scl_d;
    assign lw.scl_fall = ~lw.scl & scl_d;
    assign lw.start    = lw.scl & scl_d & sda_d & ~lw.sda;
    assign lw.stop     = lw.scl & scl_d & ~sda_d & lw.sda;
    assign lw.timeout  = lw.timeout_en && lw.busy && count == TIMEOUT_LAST;

    // Counts clock-high time of a busy bus; any line edge restarts it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            count <= 10'h000;
        else if (!lw.timeout_en || !lw.busy || !lw.scl || lw.sda != sda_d || lw.timeout)
            count <= 10'h000;
        else
            count <= count + 10'h001;
    end
endmodule // line_watch

// [core/i2c_slave_flag_handling.sv]
// Two-wire slave with address/stop and data flags, clock hold and APB registers
//
// Behaviour
// RL1: START or repeated START clears collision flag
// RL2: Software clears collision after each address interrupt
// RL3: Response command 0b11 clears data flag, next cycle
// RL4: Software waits one cycle before sampling data flag
// RL5: START wins over coincident bus timeout
// RL6: Address flag set holds SCL; clearing releases it
// RL7: Coincident set beats clear; bus never locked
// RL8: Software clears address flag when idle or SCL low
// RL9: Software checks clock hold before clearing flag
// RL10: Flags clear by writing one; zero ignored
// RL11: Line condition field reports idle encoding
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/100ps
module i2c_slave_flag_handling (
    input  wire logic        pclk,    // Peripheral clock, 20 MHz
    input  wire logic        presetn, // Asynchronous reset, active low
    input  wire logic        psel,    // APB select
    input  wire logic        penable, // APB access phase
    input  wire logic        pwrite,  // APB write
    input  wire logic [7:0]  paddr,   // APB byte address
    input  wire logic [31:0] pwdata,  // APB write data
    output logic      [31:0] prdata,  // APB read data
    output logic             pready,  // APB ready
    output logic             pslverr, // APB error on unmapped address
    input  wire logic        scl_in,  // Clock line input
    output logic             scl_out, // Clock line output level
    output logic             scl_oe,  // Clock line driven low
    input  wire logic        sda_in,  // Data line input
    output logic             sda_out, // Data line output level
    output logic             sda_oe,  // Data line driven low
    output logic             irq      // Level interrupt
);
    line_if lw ();

    line_watch u_watch (
        .pclk    (pclk),
        .presetn (presetn),
        .scl_in  (scl_in),
        .sda_in  (sda_in),
        .lw      (lw.watcher)
    );

    i2c_flags_pkg::state_t state;
    logic [2:0] ctrl;
    logic [4:0] mask;
    logic [6:0] own_addr;
    logic [7:0] tx_data;
    logic [7:0] rx_data;
    logic [7:0] shift;
    logic [3:0] bitcnt;
    logic [1:0] line_condition;
    logic       data_flag;
    logic       address_stop_flag;
    logic       slave_clock_hold;
    logic       collision;
    logic       dir;
    logic       addressed;
    logic       nack_seen;
    logic       sda_drive;
    logic       dclr_pending;
    logic       hold_data;
    logic [4:0] status;

    function automatic logic at(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    logic acc_wr, wr_status, cmd_resp, cmd_done, mapped;
    logic set_af, set_df, clr_af, clr_df, rel_addr, rel_data;

    assign acc_wr    = psel && penable && pwrite;
    assign wr_status = acc_wr && at(paddr, i2c_flags_pkg::OFF_STATUS);
    assign cmd_resp  = acc_wr && at(paddr, i2c_flags_pkg::OFF_CMD)
                       && pwdata[1:0] == i2c_flags_pkg::CMD_RESPONSE;
    assign cmd_done  = acc_wr && at(paddr, i2c_flags_pkg::OFF_CMD)
                       && pwdata[1:0] == i2c_flags_pkg::CMD_COMPLETE;
    assign mapped    = paddr[7:5] == 3'h0 && paddr[1:0] == 2'h0 && paddr[4:2] != 3'h7;
    assign pready    = 1'b1;
    assign pslverr   = psel && penable && !mapped;

    assign set_af = (state == i2c_flags_pkg::S_ADDR_ACK && lw.scl_fall)
                    || (lw.stop && addressed && ctrl[i2c_flags_pkg::CTRL_STOPIE]);
    assign set_df = (state == i2c_flags_pkg::S_RX_DATA && lw.scl_fall
                     && bitcnt == i2c_flags_pkg::NBITS)
                    || (state == i2c_flags_pkg::S_TX_ACK && lw.scl_fall && !nack_seen);
    assign clr_af = wr_status && pwdata[i2c_flags_pkg::ST_ADDR];                   // [RL10]
    assign clr_df = (wr_status && pwdata[i2c_flags_pkg::ST_DATA]) || dclr_pending;  // [RL10]
    // A clear landing in the set cycle is ignored here, so the hold stays with its flag
    assign rel_addr = state == i2c_flags_pkg::S_HOLD_ADDR && (clr_af || cmd_resp); // [RL6] [RL7]
    assign rel_data = hold_data && cmd_resp;

    assign lw.timeout_en = ctrl[i2c_flags_pkg::CTRL_TOEN];
    assign lw.busy       = line_condition == i2c_flags_pkg::LINE_BUSY;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl     <= i2c_flags_pkg::CTRL_RST;
            mask     <= i2c_flags_pkg::MASK_RST;
            own_addr <= i2c_flags_pkg::ADDR_RST;
            tx_data  <= 8'h00;
        end
        else if (acc_wr)
        begin
            if (at(paddr, i2c_flags_pkg::OFF_CTRL))
                ctrl <= pwdata[2:0];
            if (at(paddr, i2c_flags_pkg::OFF_MASK))
                mask <= pwdata[4:0];
            if (at(paddr, i2c_flags_pkg::OFF_ADDR))
                own_addr <= pwdata[6:0];
            if (at(paddr, i2c_flags_pkg::OFF_DATA))
                tx_data <= pwdata[7:0];
        end
    end

    // Read data is captured in the setup cycle and shown in the access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (psel && !penable)
        begin
            unique case (paddr)
                i2c_flags_pkg::OFF_CTRL:   prdata <= {29'h0000_0000, ctrl};
                i2c_flags_pkg::OFF_STATUS: prdata <= {27'h0000_0000, status};
                i2c_flags_pkg::OFF_MASK:   prdata <= {27'h0000_0000, mask};
                i2c_flags_pkg::OFF_ADDR:   prdata <= {25'h0000_0000, own_addr};
                i2c_flags_pkg::OFF_DATA:   prdata <= {24'h0000_0000, rx_data};
                i2c_flags_pkg::OFF_LINE:   prdata <= {30'h0000_0000, line_condition}; // [RL11]
                default:                   prdata <= 32'h0000_0000;
            endcase
        end
    end

    assign status = {dir, collision, slave_clock_hold, address_stop_flag, data_flag};
    assign irq    = |(status & mask & i2c_flags_pkg::FLAG_BITS);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            address_stop_flag <= 1'b0;
        else if (set_af)                                    // [RL7]
            address_stop_flag <= 1'b1;
        else if (clr_af)                                    // [RL10]
            address_stop_flag <= 1'b0;
    end

    // The response command clears the data flag one cycle late
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dclr_pending <= 1'b0;
            data_flag    <= 1'b0;
        end
        else
        begin
            dclr_pending <= cmd_resp;                       // [RL3]
            if (set_df)
                data_flag <= 1'b1;
            else if (clr_df)                                // [RL3]
                data_flag <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            collision <= 1'b0;
        else if (state == i2c_flags_pkg::S_TX_DATA && lw.scl_rise && !sda_drive && !lw.sda)
            collision <= 1'b1;
        else if (lw.start)                                  // [RL1]
            collision <= 1'b0;
        else if (wr_status && pwdata[i2c_flags_pkg::ST_COLL])
            collision <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            slave_clock_hold <= 1'b0;
            hold_data        <= 1'b0;
        end
        else if (set_af && !lw.stop)                        // [RL6] [RL7]
            slave_clock_hold <= 1'b1;
        else if (set_df)
        begin
            slave_clock_hold <= 1'b1;
            hold_data        <= 1'b1;
        end
        else if (rel_addr || rel_data || cmd_done)          // [RL6]
        begin
            slave_clock_hold <= 1'b0;
            hold_data        <= 1'b0;
        end
    end

    assign scl_out = 1'b0;
    assign scl_oe  = slave_clock_hold;                      // [RL6]
    assign sda_out = 1'b0;
    assign sda_oe  = sda_drive;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            line_condition <= i2c_flags_pkg::LINE_UNKNOWN;
        else if (lw.start)                                  // [RL5]
            line_condition <= i2c_flags_pkg::LINE_BUSY;
        else if (lw.stop || lw.timeout)
            line_condition <= i2c_flags_pkg::LINE_IDLE;     // [RL11]
    end

    // Byte engine: START first, so a coincident timeout cannot drop the frame
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state     <= i2c_flags_pkg::S_IDLE;
            bitcnt    <= 4'h0;
            shift     <= 8'h00;
            rx_data   <= 8'h00;
            sda_drive <= 1'b0;
            dir       <= 1'b0;
            addressed <= 1'b0;
            nack_seen <= 1'b0;
        end
        else if (!ctrl[i2c_flags_pkg::CTRL_EN])
        begin
            state     <= i2c_flags_pkg::S_IDLE;
            sda_drive <= 1'b0;
            addressed <= 1'b0;
        end
        else if (lw.start)                                  // [RL5]
        begin
            state     <= i2c_flags_pkg::S_ADDR;
            bitcnt    <= 4'h0;
            sda_drive <= 1'b0;
            addressed <= 1'b0;
        end
        else if (lw.stop || lw.timeout || cmd_done)
        begin
            state     <= i2c_flags_pkg::S_IDLE;
            sda_drive <= 1'b0;
            addressed <= 1'b0;
        end
        else
        begin
            unique case (state)
                i2c_flags_pkg::S_IDLE: ;
                i2c_flags_pkg::S_ADDR, i2c_flags_pkg::S_RX_DATA:
                begin
                    if (lw.scl_rise)
                    begin
                        shift  <= {shift[6:0], lw.sda};
                        bitcnt <= bitcnt + 4'h1;
                    end
                    else if (lw.scl_fall && bitcnt == i2c_flags_pkg::NBITS)
                    begin
                        bitcnt <= 4'h0;
                        if (state == i2c_flags_pkg::S_RX_DATA)
                        begin
                            rx_data <= shift;
                            state   <= i2c_flags_pkg::S_RX_ACK;
                        end
                        else if (shift[7:1] == own_addr)
                        begin
                            sda_drive <= 1'b1;
                            dir       <= shift[0];
                            addressed <= 1'b1;
                            state     <= i2c_flags_pkg::S_ADDR_ACK;
                        end
                        else
                            state <= i2c_flags_pkg::S_IDLE;
                    end
                end
                i2c_flags_pkg::S_ADDR_ACK:
                begin
                    if (lw.scl_fall)
                    begin
                        sda_drive <= 1'b0;
                        state     <= i2c_flags_pkg::S_HOLD_ADDR;
                    end
                end
                i2c_flags_pkg::S_HOLD_ADDR:
                begin
                    if (rel_addr)
                    begin
                        shift     <= tx_data;
                        sda_drive <= dir && !tx_data[7];
                        state     <= dir ? i2c_flags_pkg::S_TX_DATA : i2c_flags_pkg::S_RX_DATA;
                    end
                end
                i2c_flags_pkg::S_RX_ACK:
                begin
                    // Waits for the response command, then drives the chosen ACK bit
                    if (rel_data)
                        sda_drive <= !pwdata[i2c_flags_pkg::CMD_ACKACT];
                    else if (lw.scl_fall && !hold_data)
                    begin
                        sda_drive <= 1'b0;
                        state     <= i2c_flags_pkg::S_RX_DATA;
                    end
                end
                i2c_flags_pkg::S_TX_DATA:
                begin
                    if (lw.scl_rise)
                        bitcnt <= bitcnt + 4'h1;
                    else if (lw.scl_fall && bitcnt == i2c_flags_pkg::NBITS)
                    begin
                        bitcnt    <= 4'h0;
                        sda_drive <= 1'b0;
                        state     <= i2c_flags_pkg::S_TX_ACK;
                    end
                    else if (lw.scl_fall)
                    begin
                        shift     <= {shift[6:0], 1'b0};
                        sda_drive <= !shift[6];
                    end
                end
                i2c_flags_pkg::S_TX_ACK:
                begin
                    if (lw.scl_rise)
                        nack_seen <= lw.sda;
                    else if (lw.scl_fall && nack_seen)
                        state <= i2c_flags_pkg::S_IDLE;
                    else if (rel_data)
                    begin
                        shift     <= tx_data;
                        sda_drive <= !tx_data[7];
                        state     <= i2c_flags_pkg::S_TX_DATA;
                    end
                end
            endcase
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    collision_clear_a: assert property (lw.start |=> !collision) // [RL1]
        else $error("collision flag survived a start");
    data_clear_a: assert property (                               // [RL3]
        cmd_resp && data_flag |=> data_flag ##1 !data_flag)
        else $error("data flag not cleared one cycle after response");
    start_wins_a: assert property (                                // [RL5]
        lw.start && lw.timeout && ctrl[i2c_flags_pkg::CTRL_EN]
        |=> state == i2c_flags_pkg::S_ADDR && line_condition == i2c_flags_pkg::LINE_BUSY)
        else $error("start lost to timeout");
    hold_release_a: assert property (                              // [RL6]
        state == i2c_flags_pkg::S_HOLD_ADDR && clr_af && !set_af |=> !scl_oe)
        else $error("clock hold not released by flag clear");
    set_priority_a: assert property (                              // [RL7]
        set_af && clr_af && !lw.stop |=> address_stop_flag && slave_clock_hold)
        else $error("set lost to coincident clear");
    hold_flag_a: assert property (                                 // [RL7]
        scl_oe |-> address_stop_flag || data_flag || $past(data_flag))
        else $error("clock held with no flag to clear");
    w1c_zero_a: assert property (                                  // [RL10]
        wr_status && !pwdata[i2c_flags_pkg::ST_ADDR] && address_stop_flag
        |=> address_stop_flag)
        else $error("zero write cleared address flag");
    stop_idle_a: assert property (                                 // [RL11]
        lw.stop && !lw.start |=> line_condition == i2c_flags_pkg::LINE_IDLE [*1] ##1
        line_condition != i2c_flags_pkg::LINE_UNKNOWN)
        else $error("stop did not report idle");

    address_hit_c: cover property (set_af && !lw.stop ##[1:200] rel_addr);
    data_resp_c: cover property (set_df ##[1:200] cmd_resp);
    coincide_c: cover property (set_af && clr_af);
endmodule // i2c_slave_flag_handling

// [dv/i2c_bus_master.sv]
// Behavioural two-wire bus master with open-drain outputs
`timescale 1ns/100ps
module i2c_bus_master (
    input  wire logic scl_w,   // Resolved clock line
    input  wire logic sda_w,   // Resolved data line
    output logic      scl_low, // Pull clock line low
    output logic      sda_low  // Pull data line low
);
    initial
    begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end

    // Serves a first START and a repeated START alike
    task automatic start_cond();
        sda_low = 1'b0;
        #100;
        scl_low = 1'b0;
        wait (scl_w);
        #200;
        sda_low = 1'b1;
        #200;
        scl_low = 1'b1;
    endtask

    // Waiting on the resolved line lets a slave stretch the clock
    task automatic bit_io(input logic b, output logic r);
        sda_low = !b;
        #200;
        scl_low = 1'b0;
        wait (scl_w);
        #100;
        r = sda_w;
        #100;
        scl_low = 1'b1;
    endtask

    // Eight bits MSB first, then the acknowledge slot
    task automatic byte_io(input logic [8:0] b, output logic [8:0] r);
        for (int i = 8; i >= 0; i--)
            bit_io(b[i], r[i]);
    endtask

    // Clock stands still high once the frame is over
    task automatic stop_cond();
        sda_low = 1'b1;
        #200;
        scl_low = 1'b0;
        wait (scl_w);
        #200;
        sda_low = 1'b0;
        #200;
    endtask
endmodule // i2c_bus_master

// [dv/test_i2c_slave_flag_handling.sv]
// Self-checking bench for the two-wire slave flag block
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module test_i2c_slave_flag_handling;
    typedef struct {logic [32:0] e; logic [32:0] m;} note_t;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        scl_oe;
    logic        sda_oe;
    logic        scl_low;
    logic        sda_low;
    logic        irq;
    wire         scl_w = !(scl_oe | scl_low);
    wire         sda_w = !(sda_oe | sda_low);
    int          failures = 0;
    int          n_checks = 0;
    note_t       notes[$];
    note_t       cur;
    logic [8:0]  rx;
    logic [7:0]  dbyte;

    i2c_slave_flag_handling uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl_w),
        .scl_out(), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(), .sda_oe(sda_oe),
        .irq(irq));
    i2c_bus_master partner (.scl_w(scl_w), .sda_w(sda_w), .scl_low(scl_low),
        .sda_low(sda_low));

    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m = '1);
        notes.push_back('{e, m});
        apb(a, 1'b0, 32'h0000_0000);
    endtask

    // Read data and error flag are judged at the completing edge
    always @(posedge pclk)
        if (psel && penable && pready && !pwrite)
        begin
            cur = notes.pop_front();
            `CHK("read", cur.e & cur.m, {pslverr, prdata} & cur.m)
        end

    task automatic stop_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        repeat (40000) @(posedge pclk);
        failures++;
        stop_test();
    end

    initial
    begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0000_0000;
        presetn = 1'b0;
        void'($urandom(32'hf3e0));
        dbyte = 8'($urandom);
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd(i2c_flags_pkg::OFF_CTRL, 33'h0);
        rd(i2c_flags_pkg::OFF_MASK, 33'h0);
        rd(i2c_flags_pkg::OFF_STATUS, 33'h0);
        rd(i2c_flags_pkg::OFF_LINE, 33'h0);
        rd(8'h1c, {1'b1, 32'h0000_0000});
        apb(i2c_flags_pkg::OFF_CTRL, 1'b1, 32'h0000_0005);
        apb(i2c_flags_pkg::OFF_ADDR, 1'b1, 32'h0000_002a);
        apb(i2c_flags_pkg::OFF_MASK, 1'b1, 32'h0000_000b);
        // Master writes one random byte
        partner.start_cond();
        partner.byte_io({7'h2a, 1'b0, 1'b1}, rx);
        // The slave sees the ACK clock fall only after its two-flop synchroniser
        repeat (4) @(posedge pclk);
        `CHK("address ack", 1'b0, rx[0])
        `CHK("clock hold", 1'b1, scl_oe)
        `CHK("irq", 1'b1, irq)
        apb(i2c_flags_pkg::OFF_STATUS, 1'b1, 32'h0000_0000);
        apb(i2c_flags_pkg::OFF_MASK, 1'b1, 32'h0000_0000);
        rd(i2c_flags_pkg::OFF_STATUS, 33'h6);
        `CHK("irq masked", 1'b0, irq)
        apb(i2c_flags_pkg::OFF_MASK, 1'b1, 32'h0000_000b);
        apb(i2c_flags_pkg::OFF_STATUS, 1'b1, 32'h0000_0002);
        rd(i2c_flags_pkg::OFF_STATUS, 33'h0);
        `CHK("clock released", 1'b0, scl_oe)
        fork
            partner.byte_io({dbyte, 1'b1}, rx);
            begin
                wait (scl_oe === 1'b1);
                rd(i2c_flags_pkg::OFF_STATUS, 33'h5);
                apb(i2c_flags_pkg::OFF_CMD, 1'b1, 32'h0000_0003);
                @(posedge pclk);
                rd(i2c_flags_pkg::OFF_STATUS, 33'h0);
                rd(i2c_flags_pkg::OFF_DATA, {25'h0, dbyte});
            end
        join
        `CHK("data ack", 1'b0, rx[0])
        partner.stop_cond();
        rd(i2c_flags_pkg::OFF_LINE, {31'h0, i2c_flags_pkg::LINE_IDLE});
        // Master reads and collides on the first bit
        partner.start_cond();
        partner.byte_io({7'h2a, 1'b1, 1'b1}, rx);
        // Let the address flag settle so the clear cannot meet its set
        repeat (4) @(posedge pclk);
        apb(i2c_flags_pkg::OFF_DATA, 1'b1, 32'h0000_00ff);
        apb(i2c_flags_pkg::OFF_STATUS, 1'b1, 32'h0000_000b);
        partner.byte_io({8'h7f, 1'b1}, rx);
        rd(i2c_flags_pkg::OFF_STATUS, 33'h8, 33'h8);
        `CHK("irq collision", 1'b1, irq)
        partner.start_cond();
        rd(i2c_flags_pkg::OFF_STATUS, 33'h0, 33'h8);
        partner.byte_io({7'h31, 1'b0, 1'b1}, rx);
        `CHK("foreign address nack", 1'b1, rx[0])
        partner.stop_cond();
        apb(i2c_flags_pkg::OFF_STATUS, 1'b1, 32'h0000_000b);
        rd(i2c_flags_pkg::OFF_STATUS, 33'h0, 33'hb);
        `CHK("irq cleared", 1'b0, irq)
        stop_test();
    end
endmodule // test_i2c_slave_flag_handling
